/* File: rtl/lobx_consts.svh */
`ifndef LOBX_CONSTS_SVH
`define LOBX_CONSTS_SVH

// opcodes
`define LOBX_OP_XOR_REG_REG 8'h26
`define LOBX_OP_OR_MEM_TO_REG 8'ha7
`define LOBX_OP_OR_DIRECT_WORD 8'hb7
`define LOBX_OP_OR_NIBBLE_IMMEDIATE 8'h37
`define LOBX_OP_OR_MEM_MEM 8'h67
`define LOBX_OP_OR_REG_REG 8'h27
`define LOBX_OP_JUMP_POST_INDEXED 8'hed
`define LOBX_OP_JUMP_PRE_INDEXED 8'hec
`define LOBX_OP_INCREMENT_ONE_AND_JUMP 8'he4
`define LOBX_OP_INCREMENT_TWO_AND_JUMP 8'he5

// instruction word fields, bit 15 of the word is the msb
`define LOBX_FLD_OPC_HI 15
`define LOBX_FLD_OPC_LO 8
`define LOBX_FLD_IND1 7
`define LOBX_FLD_R1_HI 6
`define LOBX_FLD_R1_LO 4
`define LOBX_FLD_IND2 3
`define LOBX_FLD_R2_HI 2
`define LOBX_FLD_R2_LO 0
`define LOBX_FLD_NIB_HI 7
`define LOBX_FLD_NIB_LO 4

// loop increments
`define LOBX_INC_ONE 16'h0001
`define LOBX_INC_TWO 16'h0002

// software registers, byte addresses
`define LOBX_REG_CTRL 8'h00
`define LOBX_REG_STATUS 8'h04
`define LOBX_REG_PC 8'h08
`define LOBX_REG_LAST_IR 8'h0c
`define LOBX_CTRL_RUN 0
`define LOBX_STATUS_BUSY 0
`define LOBX_STATUS_ILLEGAL 1
`define LOBX_PC_RESET 16'h0000
`define LOBX_IR_RESET 16'h0000

`endif

/* File: rtl/lobx_pkg.sv */
package lobx_pkg;

  typedef enum logic [3:0] {
    LOBX_ST_FETCH,
    LOBX_ST_IRW,
    LOBX_ST_OPBEGIN,
    LOBX_ST_REGW,
    LOBX_ST_BASEW,
    LOBX_ST_IDX,
    LOBX_ST_IDXW,
    LOBX_ST_AFTIDX,
    LOBX_ST_INDW,
    LOBX_ST_DATA,
    LOBX_ST_DATAW,
    LOBX_ST_NEXT,
    LOBX_ST_EXEC,
    LOBX_ST_WRW
  } lobx_state_t;

  // how an operand is located
  typedef enum logic [2:0] {
    LOBX_K_REG,
    LOBX_K_MEM,
    LOBX_K_POST,
    LOBX_K_DIRECT,
    LOBX_K_IMM
  } lobx_kind_t;

  typedef enum logic [1:0] {
    LOBX_ALU_XOR,
    LOBX_ALU_OR,
    LOBX_ALU_ADD
  } lobx_aluop_t;

endpackage

/* File: rtl/lobx_alu.sv */
module lobx_alu (
  // control
  input wire lobx_pkg::lobx_aluop_t op_i,
  // operands
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  // result
  output logic [15:0] y_o
);

  always_comb begin
    case (op_i)
      lobx_pkg::LOBX_ALU_XOR: y_o = a_i ^ b_i; // RULE1
      lobx_pkg::LOBX_ALU_OR: y_o = a_i | b_i; // RULE4
      lobx_pkg::LOBX_ALU_ADD: y_o = a_i + b_i; // RULE12 RULE13
      default: y_o = 16'h0000;
    endcase
  end

endmodule // lobx_alu

/* File: rtl/lobx_core.sv */
`include "lobx_consts.svh"

// Notes on behaviour
// (RULE1) register-register xor: result bit is one where input bits differ.
// (RULE2) logical results are written back to wherever operand 2 came from.
// (RULE3) register operand: register itself, or storage word it addresses when indirect.
// (RULE4) inclusive or: result bit set when either input bit is set.
// (RULE5) storage operands allow plain, indexed, indirect or indexed-then-indirect addressing.
// (RULE6) direct or takes operand 1 as full 16-bit second instruction word.
// (RULE7) direct operand indexing adds register, no overflow or link effect.
// (RULE8) nibble immediate from bits 8-11 or-ed into bits 12-15, upper bits zero.
// (RULE9) memory-memory or fetches both base words after the instruction.
// (RULE10) register-register or takes each operand from register or storage.
// (RULE11) post-indexed jump always loads program counter with effective target.
// (RULE12) add-one loop: zero continues, else add one, store, branch.
// (RULE13) add-two loop: as add-one but increment is two.
// (RULE14) pre-indexed jump: index added first, then that location holds target.
// (RULE15) word layout: opcode, ind1, r1, ind2, r2 from msb downward.
// (RULE16) post-indexed jump: resolve indirection first, then add index register.
module lobx_core (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // main storage port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // general register file port
  output logic gr_rd_o,
  output logic gr_we_o,
  output logic [2:0] gr_sel_o,
  output logic [15:0] gr_wdata_o,
  input wire logic [15:0] gr_rdata_i,
  // software register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  lobx_pkg::lobx_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d, ir_q, ir_d, addr_q, addr_d, val_q, val_d;
  logic [15:0] op1_q, op1_d, op2_q, op2_d, cloc_addr_q, cloc_addr_d, loc2_addr_q, loc2_addr_d;
  logic opnd_q, opnd_d, cloc_mem_q, cloc_mem_d, loc2_mem_q, loc2_mem_d;
  logic run_q, run_d, ill_q, ill_d;
  logic mem_req_d, mem_we_d, gr_rd_d, gr_we_d;
  logic [15:0] mem_addr_d, mem_wdata_d, gr_wdata_d;
  logic [2:0] gr_sel_d;
  logic [31:0] reg_rdata_d;

  logic [7:0] opc, new_opc;
  logic [2:0] fld_r1, fld_r2, cur_r;
  logic cur_ind, is_loop, is_jump, is_logic, needs_op2, legal;
  lobx_pkg::lobx_kind_t kind1, kind2, cur_kind;
  lobx_pkg::lobx_aluop_t alu_op;
  logic [15:0] alu_a, alu_b, alu_y;

  // field decode
  assign opc = ir_q[`LOBX_FLD_OPC_HI:`LOBX_FLD_OPC_LO]; // RULE15
  assign new_opc = mem_rdata_i[`LOBX_FLD_OPC_HI:`LOBX_FLD_OPC_LO];
  assign fld_r1 = ir_q[`LOBX_FLD_R1_HI:`LOBX_FLD_R1_LO]; // RULE15
  assign fld_r2 = ir_q[`LOBX_FLD_R2_HI:`LOBX_FLD_R2_LO]; // RULE15
  assign cur_r = opnd_q ? fld_r2 : fld_r1;
  assign cur_ind = opnd_q ? ir_q[`LOBX_FLD_IND2] : ir_q[`LOBX_FLD_IND1];
  assign cur_kind = opnd_q ? kind2 : kind1;
  assign is_loop = (opc == `LOBX_OP_INCREMENT_ONE_AND_JUMP) || (opc == `LOBX_OP_INCREMENT_TWO_AND_JUMP);
  assign is_jump = (opc == `LOBX_OP_JUMP_POST_INDEXED) || (opc == `LOBX_OP_JUMP_PRE_INDEXED);
  assign is_logic = !is_loop && !is_jump;
  assign needs_op2 = !is_jump;

  always_comb begin
    case (new_opc)
      `LOBX_OP_XOR_REG_REG, `LOBX_OP_OR_MEM_TO_REG, `LOBX_OP_OR_DIRECT_WORD, `LOBX_OP_OR_NIBBLE_IMMEDIATE,
      `LOBX_OP_OR_MEM_MEM, `LOBX_OP_OR_REG_REG, `LOBX_OP_JUMP_POST_INDEXED, `LOBX_OP_JUMP_PRE_INDEXED,
      `LOBX_OP_INCREMENT_ONE_AND_JUMP, `LOBX_OP_INCREMENT_TWO_AND_JUMP: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // operand location modes per opcode
  always_comb begin
    kind2 = lobx_pkg::LOBX_K_REG;
    case (opc)
      `LOBX_OP_XOR_REG_REG, `LOBX_OP_OR_REG_REG: kind1 = lobx_pkg::LOBX_K_REG; // RULE10
      `LOBX_OP_OR_DIRECT_WORD: kind1 = lobx_pkg::LOBX_K_DIRECT; // RULE6
      `LOBX_OP_OR_NIBBLE_IMMEDIATE: kind1 = lobx_pkg::LOBX_K_IMM;
      `LOBX_OP_JUMP_POST_INDEXED: kind1 = lobx_pkg::LOBX_K_POST; // RULE11
      `LOBX_OP_OR_MEM_MEM: begin
        kind1 = lobx_pkg::LOBX_K_MEM; // RULE9
        kind2 = lobx_pkg::LOBX_K_MEM; // RULE9
      end
      default: kind1 = lobx_pkg::LOBX_K_MEM;
    endcase
  end

  // execution unit operand steering
  always_comb begin
    alu_a = op1_q;
    alu_b = op2_q;
    if (opc == `LOBX_OP_XOR_REG_REG) begin
      alu_op = lobx_pkg::LOBX_ALU_XOR; // RULE1
    end else if (is_loop) begin
      alu_op = lobx_pkg::LOBX_ALU_ADD;
      alu_a = op2_q;
      alu_b = (opc == `LOBX_OP_INCREMENT_TWO_AND_JUMP) ? `LOBX_INC_TWO : `LOBX_INC_ONE; // RULE12 RULE13
    end else begin
      alu_op = lobx_pkg::LOBX_ALU_OR; // RULE4
    end
  end

  lobx_alu u_alu (
    .op_i(alu_op),
    .a_i(alu_a),
    .b_i(alu_b),
    .y_o(alu_y)
  );

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    ir_d = ir_q;
    addr_d = addr_q;
    val_d = val_q;
    op1_d = op1_q;
    op2_d = op2_q;
    opnd_d = opnd_q;
    cloc_mem_d = cloc_mem_q;
    cloc_addr_d = cloc_addr_q;
    loc2_mem_d = loc2_mem_q;
    loc2_addr_d = loc2_addr_q;
    run_d = run_q;
    ill_d = ill_q;
    mem_req_d = 1'b0;
    mem_we_d = 1'b0;
    mem_addr_d = mem_addr_o;
    mem_wdata_d = mem_wdata_o;
    gr_rd_d = 1'b0;
    gr_we_d = 1'b0;
    gr_sel_d = gr_sel_o;
    gr_wdata_d = gr_wdata_o;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LOBX_REG_CTRL: run_d = reg_wdata_i[`LOBX_CTRL_RUN];
        `LOBX_REG_STATUS: if (reg_wdata_i[`LOBX_STATUS_ILLEGAL]) ill_d = 1'b0;
        `LOBX_REG_PC: if (state_q == lobx_pkg::LOBX_ST_FETCH) pc_d = reg_wdata_i[15:0];
        default: ;
      endcase
    end
    case (state_q)
      lobx_pkg::LOBX_ST_FETCH: begin
        if (run_q && !(reg_wr_i && reg_addr_i == `LOBX_REG_PC)) begin
          mem_req_d = 1'b1;
          mem_addr_d = pc_q;
          state_d = lobx_pkg::LOBX_ST_IRW;
        end
      end
      lobx_pkg::LOBX_ST_IRW: begin
        if (mem_ack_i) begin
          ir_d = mem_rdata_i;
          pc_d = pc_q + 16'h0001;
          opnd_d = 1'b0;
          if (legal) begin
            state_d = lobx_pkg::LOBX_ST_OPBEGIN;
          end else begin
            ill_d = 1'b1;
            run_d = 1'b0;
            state_d = lobx_pkg::LOBX_ST_FETCH;
          end
        end
      end
      lobx_pkg::LOBX_ST_OPBEGIN: begin
        case (cur_kind)
          lobx_pkg::LOBX_K_IMM: begin
            val_d = {12'h000, ir_q[`LOBX_FLD_NIB_HI:`LOBX_FLD_NIB_LO]}; // RULE8
            state_d = lobx_pkg::LOBX_ST_NEXT;
          end
          lobx_pkg::LOBX_K_REG: begin
            gr_rd_d = 1'b1;
            gr_sel_d = cur_r;
            state_d = lobx_pkg::LOBX_ST_REGW;
          end
          default: begin
            mem_req_d = 1'b1;
            mem_addr_d = pc_q; // RULE6 RULE9
            pc_d = pc_q + 16'h0001;
            state_d = lobx_pkg::LOBX_ST_BASEW;
          end
        endcase
      end
      lobx_pkg::LOBX_ST_REGW: begin
        if (cur_ind) begin
          mem_req_d = 1'b1; // RULE3
          mem_addr_d = gr_rdata_i;
          cloc_mem_d = 1'b1;
          cloc_addr_d = gr_rdata_i;
          state_d = lobx_pkg::LOBX_ST_DATAW;
        end else begin
          val_d = gr_rdata_i; // RULE3
          cloc_mem_d = 1'b0;
          cloc_addr_d = {13'h0, cur_r};
          state_d = lobx_pkg::LOBX_ST_NEXT;
        end
      end
      lobx_pkg::LOBX_ST_BASEW: begin
        if (mem_ack_i) begin
          addr_d = mem_rdata_i;
          if (cur_kind == lobx_pkg::LOBX_K_POST && cur_ind) begin
            mem_req_d = 1'b1; // RULE16
            mem_addr_d = mem_rdata_i;
            state_d = lobx_pkg::LOBX_ST_INDW;
          end else begin
            state_d = lobx_pkg::LOBX_ST_IDX;
          end
        end
      end
      lobx_pkg::LOBX_ST_IDX: begin
        if (cur_r != 3'h0) begin
          gr_rd_d = 1'b1;
          gr_sel_d = cur_r;
          state_d = lobx_pkg::LOBX_ST_IDXW;
        end else begin
          state_d = lobx_pkg::LOBX_ST_AFTIDX;
        end
      end
      lobx_pkg::LOBX_ST_IDXW: begin
        addr_d = addr_q + gr_rdata_i; // RULE5 RULE7 RULE14 RULE16
        state_d = lobx_pkg::LOBX_ST_AFTIDX;
      end
      lobx_pkg::LOBX_ST_AFTIDX: begin
        if (cur_kind == lobx_pkg::LOBX_K_DIRECT) begin
          val_d = addr_q; // RULE6 RULE7
          state_d = lobx_pkg::LOBX_ST_NEXT;
        end else if (cur_kind == lobx_pkg::LOBX_K_MEM && cur_ind) begin
          mem_req_d = 1'b1; // RULE5 RULE14
          mem_addr_d = addr_q;
          state_d = lobx_pkg::LOBX_ST_INDW;
        end else begin
          state_d = lobx_pkg::LOBX_ST_DATA;
        end
      end
      lobx_pkg::LOBX_ST_INDW: begin
        if (mem_ack_i) begin
          addr_d = mem_rdata_i;
          if (cur_kind == lobx_pkg::LOBX_K_POST) begin
            state_d = lobx_pkg::LOBX_ST_IDX; // RULE16
          end else begin
            state_d = lobx_pkg::LOBX_ST_DATA;
          end
        end
      end
      lobx_pkg::LOBX_ST_DATA: begin
        if (!opnd_q && !is_logic) begin
          val_d = addr_q; // RULE11 RULE14
          state_d = lobx_pkg::LOBX_ST_NEXT;
        end else begin
          mem_req_d = 1'b1;
          mem_addr_d = addr_q;
          cloc_mem_d = 1'b1;
          cloc_addr_d = addr_q;
          state_d = lobx_pkg::LOBX_ST_DATAW;
        end
      end
      lobx_pkg::LOBX_ST_DATAW: begin
        if (mem_ack_i) begin
          val_d = mem_rdata_i;
          state_d = lobx_pkg::LOBX_ST_NEXT;
        end
      end
      lobx_pkg::LOBX_ST_NEXT: begin
        if (!opnd_q) begin
          op1_d = val_q;
          if (needs_op2) begin
            opnd_d = 1'b1;
            state_d = lobx_pkg::LOBX_ST_OPBEGIN;
          end else begin
            state_d = lobx_pkg::LOBX_ST_EXEC;
          end
        end else begin
          op2_d = val_q;
          loc2_mem_d = cloc_mem_q; // RULE2
          loc2_addr_d = cloc_addr_q;
          state_d = lobx_pkg::LOBX_ST_EXEC;
        end
      end
      lobx_pkg::LOBX_ST_EXEC: begin
        state_d = lobx_pkg::LOBX_ST_FETCH;
        if (is_jump) begin
          pc_d = op1_q; // RULE11 RULE14
        end else if (!(is_loop && op2_q == 16'h0000)) begin
          if (is_loop) pc_d = op1_q; // RULE12 RULE13
          if (loc2_mem_q) begin
            mem_req_d = 1'b1; // RULE2
            mem_we_d = 1'b1;
            mem_addr_d = loc2_addr_q;
            mem_wdata_d = alu_y;
            state_d = lobx_pkg::LOBX_ST_WRW;
          end else begin
            gr_we_d = 1'b1; // RULE2
            gr_sel_d = loc2_addr_q[2:0];
            gr_wdata_d = alu_y;
          end
        end
      end
      lobx_pkg::LOBX_ST_WRW: begin
        if (mem_ack_i) state_d = lobx_pkg::LOBX_ST_FETCH;
      end
      default: state_d = lobx_pkg::LOBX_ST_FETCH;
    endcase
  end

  // register readback, data stand only in the cycle after the strobe
  always_comb begin
    reg_rdata_d = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LOBX_REG_CTRL: reg_rdata_d[`LOBX_CTRL_RUN] = run_q;
        `LOBX_REG_STATUS: begin
          reg_rdata_d[`LOBX_STATUS_BUSY] = (state_q != lobx_pkg::LOBX_ST_FETCH);
          reg_rdata_d[`LOBX_STATUS_ILLEGAL] = ill_q;
        end
        `LOBX_REG_PC: reg_rdata_d[15:0] = pc_q;
        `LOBX_REG_LAST_IR: reg_rdata_d[15:0] = ir_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= lobx_pkg::LOBX_ST_FETCH;
      pc_q <= `LOBX_PC_RESET;
      ir_q <= `LOBX_IR_RESET;
      addr_q <= 16'h0000;
      val_q <= 16'h0000;
      op1_q <= 16'h0000;
      op2_q <= 16'h0000;
      opnd_q <= 1'b0;
      cloc_mem_q <= 1'b0;
      cloc_addr_q <= 16'h0000;
      loc2_mem_q <= 1'b0;
      loc2_addr_q <= 16'h0000;
      run_q <= 1'b0;
      ill_q <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      gr_rd_o <= 1'b0;
      gr_we_o <= 1'b0;
      gr_sel_o <= 3'h0;
      gr_wdata_o <= 16'h0000;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      ir_q <= ir_d;
      addr_q <= addr_d;
      val_q <= val_d;
      op1_q <= op1_d;
      op2_q <= op2_d;
      opnd_q <= opnd_d;
      cloc_mem_q <= cloc_mem_d;
      cloc_addr_q <= cloc_addr_d;
      loc2_mem_q <= loc2_mem_d;
      loc2_addr_q <= loc2_addr_d;
      run_q <= run_d;
      ill_q <= ill_d;
      mem_req_o <= mem_req_d;
      mem_we_o <= mem_we_d;
      mem_addr_o <= mem_addr_d;
      mem_wdata_o <= mem_wdata_d;
      gr_rd_o <= gr_rd_d;
      gr_we_o <= gr_we_d;
      gr_sel_o <= gr_sel_d;
      gr_wdata_o <= gr_wdata_d;
      reg_rdata_o <= reg_rdata_d;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  xor_writeback_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && opc == `LOBX_OP_XOR_REG_REG // RULE1
    && !loc2_mem_q) |=> gr_we_o && gr_wdata_o == ($past(op1_q) ^ $past(op2_q)))
    else $error("xor result wrong");
  mem_writeback_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && is_logic && loc2_mem_q) // RULE2
    |=> mem_req_o && mem_we_o && mem_addr_o == $past(loc2_addr_q))
    else $error("result not written to operand 2 storage word");
  reg_indirect_a: assert property ((state_q == lobx_pkg::LOBX_ST_REGW && cur_ind) // RULE3
    |=> mem_req_o && !mem_we_o && mem_addr_o == $past(gr_rdata_i))
    else $error("indirect register operand not fetched from storage");
  or_writeback_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && opc == `LOBX_OP_OR_REG_REG // RULE4
    && !loc2_mem_q) |=> gr_we_o && gr_wdata_o == ($past(op1_q) | $past(op2_q)))
    else $error("or result wrong");
  nibble_operand_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC // RULE8
    && opc == `LOBX_OP_OR_NIBBLE_IMMEDIATE) |-> op1_q == {12'h000, ir_q[`LOBX_FLD_NIB_HI:`LOBX_FLD_NIB_LO]})
    else $error("nibble operand misplaced");
  direct_index_a: assert property ((state_q == lobx_pkg::LOBX_ST_IDXW // RULE7
    && cur_kind == lobx_pkg::LOBX_K_DIRECT) |=> addr_q == 16'($past(addr_q) + $past(gr_rdata_i)))
    else $error("direct operand indexing wrong");
  jump_post_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && opc == `LOBX_OP_JUMP_POST_INDEXED) // RULE11
    |=> pc_q == $past(op1_q) && state_q == lobx_pkg::LOBX_ST_FETCH)
    else $error("jump did not load program counter");
  loop_zero_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && is_loop && op2_q == 16'h0000) // RULE12
    |=> !mem_req_o && !gr_we_o && $stable(pc_q))
    else $error("zero loop operand branched or stored");
  loop_two_a: assert property ((state_q == lobx_pkg::LOBX_ST_EXEC && opc == `LOBX_OP_INCREMENT_TWO_AND_JUMP // RULE13
    && op2_q != 16'h0000 && !loc2_mem_q) |=> gr_we_o && gr_wdata_o == 16'($past(op2_q) + 16'h0002)
    && gr_sel_o == $past(fld_r2) && pc_q == $past(op1_q)) // RULE15
    else $error("add-two loop step wrong");

endmodule // lobx_core

/* File: bench/lobx_partner.sv */
module lobx_partner (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // storage side
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  // general register side
  input wire logic gr_rd_i,
  input wire logic gr_we_i,
  input wire logic [2:0] gr_sel_i,
  input wire logic [15:0] gr_wdata_i,
  output logic [15:0] gr_rdata_o,
  // wait cycles added before each acknowledge
  input wire logic [3:0] delay_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [0:65535];
  logic [15:0] gr [0:7];
  logic pend_q;
  logic we_q;
  logic [3:0] cnt_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;

  // outside a read strobe the register data lines carry garbage
  assign gr_rdata_o = gr_rd_i ? gr[gr_sel_i] : ~gr[gr_sel_i];

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 16'h0000;
    end else begin
      mem_ack_o <= 1'b0;
      // read data is only meaningful in the acknowledge cycle
      mem_rdata_o <= ~mem_rdata_o;
      if (gr_we_i) begin
        gr[gr_sel_i] <= gr_wdata_i;
      end
      if (mem_req_i && !pend_q) begin
        pend_q <= 1'b1;
        cnt_q <= delay_i;
        we_q <= mem_we_i;
        addr_q <= mem_addr_i;
        wdata_q <= mem_wdata_i;
      end else if (pend_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        mem_ack_o <= 1'b1;
        if (we_q) begin
          mem[addr_q] <= wdata_q;
        end else begin
          mem_rdata_o <= mem[addr_q];
        end
      end
    end
  end
endmodule // lobx_partner

/* File: bench/test_logic_or_branch_exec.sv */
`include "lobx_consts.svh"

module test_logic_or_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic in_mem;
    logic [15:0] loc;
    logic [15:0] res;
    logic [15:0] pc;
  } lobx_row_t;

  localparam logic [7:0] op_xrr = `LOBX_OP_XOR_REG_REG;
  localparam logic [7:0] op_orr = `LOBX_OP_OR_REG_REG;
  localparam logic [7:0] op_omr = `LOBX_OP_OR_MEM_TO_REG;
  localparam logic [7:0] op_odw = `LOBX_OP_OR_DIRECT_WORD;
  localparam logic [7:0] op_oni = `LOBX_OP_OR_NIBBLE_IMMEDIATE;
  localparam logic [7:0] op_omm = `LOBX_OP_OR_MEM_MEM;
  localparam logic [7:0] op_jpo = `LOBX_OP_JUMP_POST_INDEXED;
  localparam logic [7:0] op_jpr = `LOBX_OP_JUMP_PRE_INDEXED;
  localparam logic [7:0] op_ia1 = `LOBX_OP_INCREMENT_ONE_AND_JUMP;
  localparam logic [7:0] op_ia2 = `LOBX_OP_INCREMENT_TWO_AND_JUMP;

  logic clock_i;
  logic sys_rst_i;
  logic mem_req, mem_we, mem_ack, gr_rd, gr_we;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, gr_wdata, gr_rdata;
  logic [2:0] gr_sel;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [3:0] ack_delay;
  int failures = 0;
  int n_compared = 0;

  lobx_core i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .gr_rd_o(gr_rd), .gr_we_o(gr_we), .gr_sel_o(gr_sel), .gr_wdata_o(gr_wdata), .gr_rdata_i(gr_rdata),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o)
  );

  lobx_partner i_mem (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
    .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata),
    .gr_rd_i(gr_rd), .gr_we_i(gr_we), .gr_sel_i(gr_sel), .gr_wdata_i(gr_wdata), .gr_rdata_o(gr_rdata),
    .delay_i(ack_delay)
  );

  always #4 clock_i = ~clock_i;

  // word layout: opcode, first indirect, first select, second indirect, second select
  function automatic logic [15:0] enc(logic [7:0] op, int i1, int r1, int i2, int r2);
    return {op, i1[0], r1[2:0], i2[0], r2[2:0]};
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stands one cycle only, then drops to zero
  task automatic expect_reg(string what, logic [7:0] a, logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 check(what, reg_rdata_o, v);
    @(posedge clock_i);
    #1 check("rdata after read", reg_rdata_o, 32'h0);
  endtask

  task automatic wait_status(logic [31:0] want);
    logic [31:0] st;
    for (int n = 0; n < 400; n++) begin
      @(posedge clock_i);
      reg_addr_i <= `LOBX_REG_STATUS;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 st = reg_rdata_o;
      if (st === want) return;
    end
    failures++;
    $display("ERROR status wait expected %h seen %h", want, st);
    end_sim();
  endtask

  // unused storage reads as zero, which stops the core as an unknown opcode
  task automatic load_data();
    for (int a = 0; a < 65536; a++) i_mem.mem[a] = 16'h0000;
    i_mem.mem[16'h0040] = 16'h3c3c;
    i_mem.mem[16'h0043] = 16'h00a0;
    i_mem.mem[16'h0050] = 16'h0f00;
    i_mem.mem[16'h00a0] = 16'h1234;
    i_mem.mem[16'h00b0] = 16'h8001;
    i_mem.mem[16'h00c0] = 16'h00b0;
    i_mem.gr = '{16'h0000, 16'h00a0, 16'h00b0, 16'h0003, 16'h5a5a, 16'h0f0f, 16'h00c0, 16'hff00};
  endtask

  task automatic run_row(lobx_row_t r);
    logic [15:0] seen;
    load_data();
    i_mem.mem[0] = r.w0;
    i_mem.mem[1] = r.w1;
    i_mem.mem[2] = r.w2;
    reg_wr(`LOBX_REG_PC, 32'h0);
    reg_wr(`LOBX_REG_CTRL, 32'h1);
    wait_status(32'h2);
    seen = r.in_mem ? i_mem.mem[r.loc] : i_mem.gr[r.loc[2:0]];
    check("result", {16'h0, seen}, {16'h0, r.res});
    expect_reg("pc", `LOBX_REG_PC, {16'h0, r.pc});
    expect_reg("run after stop", `LOBX_REG_CTRL, 32'h0);
    reg_wr(`LOBX_REG_STATUS, 32'h2);
  endtask

  initial begin
    lobx_row_t rows [20];
    clock_i = 1'b0;
    sys_rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    ack_delay = 4'h0;
    rows[0] = '{enc(op_xrr, 0, 4, 0, 5), 16'h0, 16'h0, 1'b0, 16'h5, 16'h5555, 16'h2};
    rows[1] = '{enc(op_xrr, 1, 1, 0, 7), 16'h0, 16'h0, 1'b0, 16'h7, 16'hed34, 16'h2};
    rows[2] = '{enc(op_xrr, 0, 4, 1, 2), 16'h0, 16'h0, 1'b1, 16'hb0, 16'hda5b, 16'h2};
    rows[3] = '{enc(op_orr, 0, 4, 0, 5), 16'h0, 16'h0, 1'b0, 16'h5, 16'h5f5f, 16'h2};
    rows[4] = '{enc(op_orr, 1, 1, 1, 6), 16'h0, 16'h0, 1'b1, 16'hc0, 16'h12b4, 16'h2};
    rows[5] = '{enc(op_omr, 0, 0, 0, 5), 16'h40, 16'h0, 1'b0, 16'h5, 16'h3f3f, 16'h3};
    rows[6] = '{enc(op_omr, 0, 3, 0, 5), 16'h40, 16'h0, 1'b0, 16'h5, 16'h0faf, 16'h3};
    rows[7] = '{enc(op_omr, 1, 0, 0, 5), 16'h43, 16'h0, 1'b0, 16'h5, 16'h1f3f, 16'h3};
    rows[8] = '{enc(op_omr, 1, 3, 0, 7), 16'h40, 16'h0, 1'b0, 16'h7, 16'hff34, 16'h3};
    rows[9] = '{enc(op_odw, 0, 0, 0, 5), 16'hf000, 16'h0, 1'b0, 16'h5, 16'hff0f, 16'h3};
    rows[10] = '{enc(op_odw, 0, 3, 0, 7), 16'hfffe, 16'h0, 1'b0, 16'h7, 16'hff01, 16'h3};
    rows[11] = '{enc(op_oni, 1, 2, 0, 7), 16'h0, 16'h0, 1'b0, 16'h7, 16'hff0a, 16'h2};
    rows[12] = '{enc(op_oni, 0, 5, 1, 2), 16'h0, 16'h0, 1'b1, 16'hb0, 16'h8005, 16'h2};
    rows[13] = '{enc(op_omm, 0, 0, 0, 0), 16'h40, 16'h50, 1'b1, 16'h50, 16'h3f3c, 16'h4};
    rows[14] = '{enc(op_omm, 1, 0, 0, 3), 16'h43, 16'h40, 1'b1, 16'h43, 16'h12b4, 16'h4};
    rows[15] = '{enc(op_jpo, 1, 3, 0, 0), 16'h43, 16'h0, 1'b0, 16'h3, 16'h0003, 16'ha4};
    rows[16] = '{enc(op_jpr, 1, 3, 0, 0), 16'h40, 16'h0, 1'b0, 16'h3, 16'h0003, 16'ha1};
    rows[17] = '{enc(op_ia1, 0, 0, 1, 2), 16'h70, 16'h0, 1'b1, 16'hb0, 16'h8002, 16'h71};
    rows[18] = '{enc(op_ia1, 0, 0, 0, 0), 16'h70, 16'h0, 1'b0, 16'h0, 16'h0000, 16'h3};
    rows[19] = '{enc(op_ia2, 0, 0, 0, 5), 16'h70, 16'h0, 1'b0, 16'h5, 16'h0f11, 16'h71};
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    expect_reg("ctrl reset", `LOBX_REG_CTRL, 32'h0);
    expect_reg("status reset", `LOBX_REG_STATUS, 32'h0);
    expect_reg("pc reset", `LOBX_REG_PC, 32'h0);
    expect_reg("last ir reset", `LOBX_REG_LAST_IR, 32'h0);
    reg_wr(8'h10, 32'hffffffff);
    expect_reg("unmapped", 8'h10, 32'h0);
    // every row once with a prompt and once with a slow storage
    for (int d = 0; d < 4; d += 3) begin
      ack_delay <= d[3:0];
      foreach (rows[i]) run_row(rows[i]);
    end
    // endless add-one loop onto itself: busy, pc write refused, stop at boundary
    load_data();
    i_mem.mem[0] = enc(op_ia1, 0, 0, 0, 5);
    reg_wr(`LOBX_REG_PC, 32'h0);
    reg_wr(`LOBX_REG_CTRL, 32'h1);
    repeat (10) @(posedge clock_i);
    expect_reg("busy", `LOBX_REG_STATUS, 32'h1);
    reg_wr(`LOBX_REG_PC, 32'h55);
    reg_wr(`LOBX_REG_CTRL, 32'h0);
    wait_status(32'h0);
    expect_reg("pc after stop", `LOBX_REG_PC, 32'h0);
    expect_reg("last ir", `LOBX_REG_LAST_IR, {16'h0, enc(op_ia1, 0, 0, 0, 5)});
    // reset in mid-run
    reg_wr(`LOBX_REG_CTRL, 32'h1);
    repeat (7) @(posedge clock_i);
    sys_rst_i <= 1'b1;
    @(posedge clock_i);
    #1 check("req in reset", {31'h0, mem_req}, 32'h0);
    check("gr write in reset", {31'h0, gr_we}, 32'h0);
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    expect_reg("ctrl after reset", `LOBX_REG_CTRL, 32'h0);
    expect_reg("pc after reset", `LOBX_REG_PC, 32'h0);
    expect_reg("status after reset", `LOBX_REG_STATUS, 32'h0);
    end_sim();
  end
endmodule // test_logic_or_branch_exec
